// ===== bench/remote_uart.sv
// Remote serial transmitter model that frames characters onto the receive pin.
`timescale 1ns/100ps
`default_nettype none
module remote_uart (
  // Clock and baud tick
  input wire logic clock,
  input wire logic os_tick,
  // Serial pins
  input wire logic rts_n,
  output logic rx
);
  int tpb = 16;
  initial rx = 1'b1;
  task automatic ticks(input int n);
    repeat (n) @(posedge clock iff os_tick);
    #1;
  endtask
  // A new frame only starts while the local side grants it.
  task automatic send(input logic [7:0] b, input logic stop_bit);
    wait (rts_n == 1'b0);
    rx = 1'b0;
    ticks(tpb);
    for (int i = 0; i < 8; i++) begin
      rx = b[i];
      ticks(tpb);
    end
    rx = stop_bit;
    ticks(tpb);
    rx = 1'b1;
    ticks(tpb);
  endtask
  task automatic glitch(input int n);
    rx = 1'b0;
    ticks(n);
    rx = 1'b1;
    ticks(2 * tpb);
  endtask
endmodule // remote_uart
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking testbench for the UART receive and flow-control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import uart_rx_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic os_tick = 1'b0;
  logic [2:0] host_addr;
  logic host_rd;
  logic host_wr;
  logic [7:0] host_wdata;
  logic cts_n;
  logic [7:0] host_rdata, tx_flow_first, tx_flow_second, last_first;
  logic irq, rx, rts_n, tx_pause, tx_flow_send, tx_flow_pause_char, tx_flow_double, last_kind;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int sends = 0;
  uart_receiver_flow_control #(.DEPTH(FIFO_DEPTH)) dut_u (
    .clock(clock), .rst(rst), .os_tick(os_tick), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata), .irq(irq), .rx(rx),
    .cts_n(cts_n), .rts_n(rts_n), .tx_pause(tx_pause), .tx_flow_send(tx_flow_send),
    .tx_flow_pause_char(tx_flow_pause_char), .tx_flow_double(tx_flow_double),
    .tx_flow_first(tx_flow_first), .tx_flow_second(tx_flow_second));
  remote_uart peer_u (.clock(clock), .os_tick(os_tick), .rts_n(rts_n), .rx(rx));
  // ----------------------------------------
  // Clock, baud tick, watchdog and flow-send capture
  // ----------------------------------------
  always #2 clock = ~clock;
  always @(posedge clock) #1 os_tick = ~os_tick;
  always @(negedge clock) begin
    cycles++;
    if (tx_flow_send) begin
      sends++;
      last_kind = tx_flow_pause_char;
      last_first = tx_flow_first;
    end
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge clock);
    #1 host_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    host_addr = a;
    host_rd = 1'b1;
    @(posedge clock);
    #1 host_rd = 1'b0;
    @(posedge clock);
    #1 chk(what, host_rdata, exp);
  endtask
  task automatic enhanced_feature(input logic [7:0] v);
    wr(ADDR_LCR, ENH_KEY);
    wr(3'h2, v);
    wr(ADDR_LCR, 8'h03);
  endtask
  task automatic flow(input logic [7:0] b, input logic pause, input logic [7:0] interrupt_status);
    peer_u.send(b, 1'b1);
    chk("tx_pause", 8'(tx_pause), 8'(pause));
    rd(ADDR_ISR, interrupt_status, "isr flow");
    rd(ADDR_LSR, 8'h00, "lsr flow");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {host_addr, host_rd, host_wr, host_wdata, cts_n} = 14'h0000;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    chk("rts reset", 8'(rts_n), 8'h01);
    wr(ADDR_MCR, 8'h02);
    wr(ADDR_LCR, ENH_KEY);
    for (int a = 4; a < 8; a++) rd(3'(a), 8'h00, "flow char reset");
    wr(3'h2, 8'h10);
    wr(ADDR_LCR, 8'h03);
    wr(ADDR_ISR, 8'h01);
    for (int m = 2; m >= 0; m--) begin
      wr(ADDR_LCR, 8'h80);
      wr(3'h2, 8'(m << 4));
      wr(ADDR_LCR, 8'h03);
      peer_u.tpb = 16 >> m;
      peer_u.send(8'hA5 ^ 8'(m), 1'b1);
      rd(ADDR_LSR, 8'h01, "lsr ready");
      rd(ADDR_HOLD, 8'hA5 ^ 8'(m), "mode byte");
    end
    peer_u.glitch(3);
    peer_u.ticks(160);
    rd(ADDR_LSR, 8'h00, "false start");
    peer_u.send(8'h3C, 1'b0);
    peer_u.send(8'h5A, 1'b1);
    rd(ADDR_LSR, 8'h09, "lsr framing");
    rd(ADDR_HOLD, 8'h3C, "tagged byte");
    rd(ADDR_LSR, 8'h01, "lsr next tags");
    rd(ADDR_HOLD, 8'h5A, "next byte");
    enhanced_feature(8'h50);
    wr(ADDR_IER, 8'h40);
    wr(ADDR_MCR, 8'h02);
    peer_u.ticks(2);
    chk("rts on", 8'(rts_n), 8'h00);
    for (int i = 0; i < 16; i++) peer_u.send(8'(i), 1'b1);
    chk("rts off", 8'(rts_n), 8'h01);
    chk("irq rts", 8'(irq), 8'h01);
    rd(ADDR_ISR, 8'hE0, "isr rts");
    rd(ADDR_ISR, 8'hC1, "isr cleared");
    wr(ADDR_IER, 8'h41);
    rd(ADDR_ISR, 8'hC4, "isr trigger");
    for (int i = 0; i < 16; i++) begin
      chk("rts held", 8'(rts_n), 8'h01);
      rd(ADDR_HOLD, 8'(i), "fifo order");
    end
    peer_u.ticks(2);
    chk("rts back", 8'(rts_n), 8'h00);
    wr(ADDR_IER, 8'h01);
    peer_u.send(8'h77, 1'b1);
    rd(ADDR_ISR, 8'hC1, "isr below trigger");
    peer_u.ticks(40 * 16);
    chk("no early timeout", 8'(irq), 8'h00);
    peer_u.ticks(20 * 16);
    rd(ADDR_ISR, 8'hCC, "isr timeout");
    rd(ADDR_HOLD, 8'h77, "timeout byte");
    wr(ADDR_LCR, ENH_KEY);
    wr(3'h2, 8'h12);
    wr(3'h4, 8'h11);
    wr(3'h5, 8'h21);
    wr(3'h6, 8'h13);
    wr(3'h7, 8'h23);
    wr(ADDR_LCR, 8'h03);
    wr(ADDR_IER, 8'h20);
    flow(8'h13, 1'b1, 8'hD0);
    flow(8'h11, 1'b0, 8'hC1);
    enhanced_feature(8'h13);
    flow(8'h13, 1'b0, 8'hC1);
    flow(8'h23, 1'b1, 8'hD0);
    flow(8'h11, 1'b1, 8'hD0);
    flow(8'h21, 1'b0, 8'hC1);
    enhanced_feature(8'h10);
    cts_n = 1'b1;
    peer_u.ticks(4);
    chk("cts no auto", 8'(tx_pause), 8'h00);
    cts_n = 1'b0;
    enhanced_feature(8'h90);
    wr(ADDR_IER, 8'h80);
    cts_n = 1'b1;
    peer_u.ticks(4);
    chk("cts pause", 8'(tx_pause), 8'h01);
    rd(ADDR_ISR, 8'hE0, "isr cts");
    cts_n = 1'b0;
    peer_u.ticks(4);
    chk("cts resume", 8'(tx_pause), 8'h00);
    enhanced_feature(8'h1C);
    for (int i = 0; i < 8; i++) peer_u.send(8'h40 + 8'(i), 1'b1);
    chk("no early pause", 8'(sends), 8'h00);
    peer_u.ticks(30 * 16);
    chk("pause sent", {sends[6:0], last_kind}, 8'h03);
    chk("pause char", last_first, 8'h13);
    chk("pause second", tx_flow_second, 8'h23);
    chk("flow double", 8'(tx_flow_double), 8'h01);
    for (int i = 0; i < 8; i++) rd(ADDR_HOLD, 8'h40 + 8'(i), "drain");
    peer_u.ticks(4);
    chk("resume sent", {sends[6:0], last_kind}, 8'h04);
    chk("resume char", last_first, 8'h11);
    chk("resume second", tx_flow_second, 8'h21);
    final_report();
  end
endmodule // testbench
`default_nettype wire

// ===== bench/uart_rx_monitor.sv
// Assertion checker bound to the UART receive and flow-control block.
`timescale 1ns/100ps
`default_nettype none
module uart_rx_monitor
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic os_tick,
  // Host register port
  input wire logic [2:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic irq,
  // Serial pins
  input wire logic rx,
  input wire logic cts_n,
  input wire logic rts_n,
  // Transmitter control
  input wire logic tx_pause,
  input wire logic tx_flow_send,
  input wire logic tx_flow_pause_char,
  input wire logic tx_flow_double,
  input wire logic [7:0] tx_flow_first,
  input wire logic [7:0] tx_flow_second
);
  // ----------------------------------------
  // Recent host access and quiet receive line
  // ----------------------------------------
  logic [3:0] acc_q;
  logic [3:0] rx_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= 4'h0;
      rx_q <= 4'hF;
    end else begin
      acc_q <= {acc_q[2:0], host_rd | host_wr};
      rx_q <= {rx_q[2:0], rx};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> rts_n && !irq && !tx_pause && !tx_flow_send && host_rdata == 8'h00)
    else $error("outputs not at reset values");
  a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data changed without a read");
  a_rts_fall_cause: assert property ($fell(rts_n) |-> acc_q != 4'h0)
    else $error("rts dropped without a host access");
  a_rts_rise_cause: assert property ($rose(rts_n) |-> acc_q != 4'h0 || rx_q == 4'hF)
    else $error("rts raised without a cause");
  a_flow_send_pulse: assert property (tx_flow_send |=> !tx_flow_send)
    else $error("flow send longer than one cycle");
  a_flow_chars_upd: assert property ($changed(tx_flow_first) || $changed(tx_flow_second) |-> tx_flow_send)
    else $error("flow characters changed without send");
  a_double_follows: assert property ($changed(tx_flow_double) |-> $past(host_wr))
    else $error("double mode changed without a write");
  a_irq_cause: assert property ($rose(irq) |-> acc_q != 4'h0 || rx_q == 4'hF || cts_n)
    else $error("interrupt raised without a cause");
endmodule // uart_rx_monitor
bind uart_receiver_flow_control uart_rx_monitor #(.DEPTH(DEPTH)) monitor_u (
  .clock(clock), .rst(rst), .os_tick(os_tick), .host_addr(host_addr), .host_rd(host_rd),
  .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata), .irq(irq), .rx(rx),
  .cts_n(cts_n), .rts_n(rts_n), .tx_pause(tx_pause), .tx_flow_send(tx_flow_send),
  .tx_flow_pause_char(tx_flow_pause_char), .tx_flow_double(tx_flow_double),
  .tx_flow_first(tx_flow_first), .tx_flow_second(tx_flow_second));
`default_nettype wire

// ===== pkg/uart_rx_pkg.sv
// Constants, types and decode functions for the UART receive and flow-control block.
`default_nettype none
package uart_rx_pkg;
  // ----------------------------------------
  // Register offsets on the host port
  // ----------------------------------------
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_PAUSE_CHAR_FIRST = 3'h6;
  localparam logic [2:0] ADDR_PAUSE_CHAR_SECOND = 3'h7;
  localparam logic [7:0] ENH_KEY = 8'hBF;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // Interrupt status codes
  // ----------------------------------------
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [5:0] ISR_RX_DATA = 6'h04;
  localparam logic [5:0] ISR_TIMEOUT = 6'h0C;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_RTSCTS = 6'h20;
  // ----------------------------------------
  // Sizes and counts
  // ----------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam int ENTRY_W = 11;
  localparam logic [6:0] TIMEOUT_WORDS = 7'd4;
  localparam logic [6:0] TIMEOUT_EXTRA_BITS = 7'd12;
  localparam logic [5:0] XOFF_DELAY_CHARS = 6'd2;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;

  // Oversampling clocks per bit for field value 0, 1, 2 (16x, 8x, 4x).
  function automatic logic [4:0] bit_clocks(input logic [1:0] sel);
    case (sel)
      2'b01: bit_clocks = 5'd8;
      2'b10: bit_clocks = 5'd4;
      default: bit_clocks = 5'd16;
    endcase
  endfunction

  function automatic logic [5:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'b00: trig_level = 6'd8;
      2'b01: trig_level = 6'd16;
      2'b10: trig_level = 6'd24;
      default: trig_level = 6'd30;
    endcase
  endfunction

  function automatic logic [5:0] upper_level(input logic [1:0] sel);
    case (sel)
      2'b00: upper_level = 6'd16;
      2'b01: upper_level = 6'd24;
      2'b10: upper_level = 6'd30;
      default: upper_level = 6'd30;
    endcase
  endfunction

  function automatic logic [5:0] lower_level(input logic [1:0] sel);
    case (sel)
      2'b00: lower_level = 6'd0;
      2'b01: lower_level = 6'd8;
      2'b10: lower_level = 6'd16;
      default: lower_level = 6'd24;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== rtl/rx_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill count.
`timescale 1ns/100ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign count = cnt_q;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
    end
  end
endmodule // rx_fifo
`default_nettype wire

// ===== rtl/uart_receiver_flow_control.sv
// UART receive path with error-tagged FIFO, timeout, auto RTS/CTS and Xon/Xoff flow control.
//
// Behaviour
// - Start edge begins count; start sampled after 8/4/2 clocks, accepted only if low.
// - Receive shifter timed by 16x, 8x or 4x clock from fractional divisor bits 5:4.
// - Data and stop sampled at bit centre; parity, framing, break in line status 4:2.
// - Receive FIFO holds 32 entries of 8 data bits plus 3 error tags.
// - Reading receive holding pops FIFO; line status 4:2 then show next byte's tags.
// - Data-ready interrupt per character or at trigger level, enabled by enable bit 0.
// - Timeout interrupt after four word lengths plus 12 bit times with data waiting.
// - With enable bit 6 and feature bit 4, RTS rising sets status bit 5, interrupts.
// - Auto RTS goes high at 16/24/30/30 characters; reception continues until full.
// - RTS returns low when fill drains to 0/8/16/24 characters.
// - Auto CTS transmit gating only when feature bit 7 is set.
// - With enable bit 7 and feature bit 4, CTS rising sets status bit 5, interrupts.
// - CTS high pauses transmitter after current stop bit; low resumes it.
// - Received characters compared with pause values; match halts transmitter after character.
// - Pause match sets pause flag and interrupts when enable bit 5 is set.
// - While paused, resume value match restarts transmitter and clears status bit 4.
// - Reset clears all four 8-bit resume and pause character registers.
// - Double mode needs two consecutive characters matching first and second values.
// - Characters consumed as flow-control matches never enter the receive FIFO.
// - Auto pause send two character times after fill reaches 8/16/24/30 trigger.
// - After pause sent, resume characters sent when fill drops to 0/8/16/24.
`timescale 1ns/100ps
`default_nettype none
module uart_receiver_flow_control
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Oversampling enable from the baud generator
  input wire logic os_tick,
  // Host register port
  input wire logic [2:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic irq,
  // Serial pins
  input wire logic rx,
  input wire logic cts_n,
  output logic rts_n,
  // Local transmitter control
  output logic tx_pause,
  output logic tx_flow_send,
  output logic tx_flow_pause_char,
  output logic tx_flow_double,
  output logic [7:0] tx_flow_first,
  output logic [7:0] tx_flow_second
);
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] lcr_q, ier_q, mcr_q, efr_q, frac_q;
  logic [7:0] on1_q, on2_q, off1_q, off2_q;
  logic fifo_en_q;
  logic [1:0] trig_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_val;

  wire enh = (lcr_q == ENH_KEY);
  wire divl = lcr_q[7] & ~enh;
  wire wr_ier = host_wr & (host_addr == ADDR_IER) & ~lcr_q[7];
  wire wr_isr = host_wr & (host_addr == ADDR_ISR);
  wire rd_hold = host_rd & (host_addr == ADDR_HOLD) & ~lcr_q[7];
  wire rd_isr = host_rd & (host_addr == ADDR_ISR) & ~lcr_q[7];
  wire rd_lsr = host_rd & (host_addr == ADDR_LSR) & ~enh;
  wire flush = wr_isr & ~lcr_q[7] & host_wdata[1];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lcr_q <= REG_RESET;
      ier_q <= REG_RESET;
      mcr_q <= REG_RESET;
      efr_q <= REG_RESET;
      frac_q <= REG_RESET;
      on1_q <= REG_RESET;
      on2_q <= REG_RESET;
      off1_q <= REG_RESET;
      off2_q <= REG_RESET;
      fifo_en_q <= 1'b0;
      trig_q <= 2'b00;
    end else if (host_wr) begin
      case (host_addr)
        ADDR_IER: if (wr_ier) ier_q <= efr_q[4] ? host_wdata : {ier_q[7:4], host_wdata[3:0]};
        ADDR_ISR: begin
          if (enh) efr_q <= host_wdata;
          else if (divl) frac_q <= host_wdata;
          else if (~lcr_q[7]) begin
            fifo_en_q <= host_wdata[0];
            trig_q <= host_wdata[7:6];
          end
        end
        ADDR_LCR: lcr_q <= host_wdata;
        ADDR_MCR: if (enh) on1_q <= host_wdata; else mcr_q <= host_wdata;
        ADDR_LSR: if (enh) on2_q <= host_wdata;
        ADDR_PAUSE_CHAR_FIRST: if (enh) off1_q <= host_wdata;
        ADDR_PAUSE_CHAR_SECOND: if (enh) off2_q <= host_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Receive and CTS pin synchronisers
  // ----------------------------------------
  logic rx1_q, rx2_q, rx3_q, rxs_q;
  logic ct1_q, ct2_q, ct3_q, cts_q;
  wire cts_d = (ct2_q == ct3_q) ? ct3_q : cts_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {rx1_q, rx2_q, rx3_q, rxs_q} <= 4'hF;
      {ct1_q, ct2_q, ct3_q, cts_q} <= 4'hF;
    end else begin
      {rx1_q, rx2_q, rx3_q} <= {rx, rx1_q, rx2_q};
      if (rx2_q == rx3_q) rxs_q <= rx3_q;
      {ct1_q, ct2_q, ct3_q} <= {cts_n, ct1_q, ct2_q};
      cts_q <= cts_d;
    end
  end

  // ----------------------------------------
  // Receive shifter
  // ----------------------------------------
  rx_state_t st_q;
  logic [4:0] os_q;
  logic [3:0] nbit_q;
  logic [8:0] sh_q;
  logic char_v;
  logic [7:0] char_d;
  logic [2:0] char_tag;
  logic rxp_q;
  // Only a falling edge starts a frame, so a line still low after a bad stop bit does not re-trigger.
  wire rx_fall = rxp_q & ~rxs_q;

  wire [4:0] bitclk = bit_clocks(frac_q[5:4]);
  wire [4:0] half = {1'b0, bitclk[4:1]};
  wire [3:0] wl = {2'b00, lcr_q[1:0]} + 4'd5;
  wire [3:0] nframe = wl + {3'b000, lcr_q[3]};
  wire [7:0] wmask = 8'hFF >> (4'd8 - wl);
  wire [7:0] rx_word = sh_q[7:0] & wmask;
  wire rx_par = lcr_q[3] ? sh_q[wl] : 1'b0;
  wire par_err = lcr_q[3] & ~lcr_q[5] & ((^rx_word) ^ rx_par ^ ~lcr_q[4]);
  wire brk = (rx_word == 8'h00) & ~rx_par & ~rxs_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= RX_IDLE;
      os_q <= 5'd0;
      nbit_q <= 4'd0;
      sh_q <= 9'h000;
      char_v <= 1'b0;
      char_d <= 8'h00;
      char_tag <= 3'b000;
      rxp_q <= 1'b1;
    end else begin
      char_v <= 1'b0;
      rxp_q <= rxs_q;
      case (st_q)
        RX_IDLE: begin
          os_q <= 5'd0;
          if (rx_fall) st_q <= RX_START;
        end
        RX_START: if (os_tick) begin
          os_q <= os_q + 5'd1;
          if (os_q == half - 5'd1) begin
            os_q <= 5'd0;
            nbit_q <= 4'd0;
            st_q <= rxs_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (os_tick) begin
          os_q <= os_q + 5'd1;
          if (os_q == bitclk - 5'd1) begin
            os_q <= 5'd0;
            sh_q <= {rxs_q, sh_q[8:1]};
            nbit_q <= nbit_q + 4'd1;
            if (nbit_q == nframe - 4'd1) st_q <= RX_STOP;
          end
        end
        RX_STOP: if (os_tick) begin
          os_q <= os_q + 5'd1;
          if (os_q == bitclk - 5'd1) begin
            st_q <= RX_IDLE;
            char_v <= 1'b1;
            char_d <= rx_word;
            char_tag <= {brk, ~rxs_q, par_err};
          end
        end
        default: st_q <= RX_IDLE;
      endcase
      if (st_q == RX_DATA && os_tick && os_q == bitclk - 5'd1 && nbit_q == nframe - 4'd1) begin
        sh_q <= 9'({rxs_q, sh_q[8:1]} >> (4'd9 - nframe));
      end
    end
  end

  // ----------------------------------------
  // Software flow-control filter
  // ----------------------------------------
  logic pend_q, pend_off_q, late_q, susp_q, xoff_flag_q;
  logic [10:0] pend_d, late_d;
  wire [10:0] entry = {char_tag, char_d};
  wire dbl = (efr_q[1:0] == 2'b11);
  wire sgl = ^efr_q[1:0];
  wire [7:0] sel_off = efr_q[1] ? off1_q : off2_q;
  wire [7:0] sel_on = efr_q[1] ? on1_q : on2_q;
  wire m_off1 = ((char_d ^ off1_q) & wmask) == 8'h00;
  wire m_off2 = ((char_d ^ off2_q) & wmask) == 8'h00;
  wire m_on1 = ((char_d ^ on1_q) & wmask) == 8'h00;
  wire m_on2 = ((char_d ^ on2_q) & wmask) == 8'h00;
  wire m_soff = ((char_d ^ sel_off) & wmask) == 8'h00;
  wire m_son = ((char_d ^ sel_on) & wmask) == 8'h00;
  wire pair_off = pend_q & pend_off_q & m_off2;
  wire pair_on = pend_q & ~pend_off_q & m_on2;
  wire start_pair = dbl & ~pend_q & (m_off1 | (susp_q & m_on1));
  wire do_off = char_v & (sgl ? m_soff : dbl & pair_off);
  wire do_on = char_v & susp_q & (sgl ? ~m_soff & m_son : dbl & pair_on);
  wire pend_break = char_v & dbl & pend_q & ~pair_off & ~pair_on;
  wire push_char = char_v & ~do_off & ~do_on & ~start_pair & ~pend_break;
  wire push_v = push_char | pend_break | late_q;
  wire [10:0] push_d = pend_break ? pend_d : (late_q ? late_d : entry);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_off_q <= 1'b0;
      pend_d <= 11'h000;
      late_q <= 1'b0;
      late_d <= 11'h000;
      susp_q <= 1'b0;
      xoff_flag_q <= 1'b0;
    end else begin
      late_q <= pend_break;
      if (pend_break) late_d <= entry;
      if (char_v) pend_q <= char_v & start_pair;
      if (char_v & start_pair) begin
        pend_off_q <= m_off1;
        pend_d <= entry;
      end
      if (do_off) susp_q <= 1'b1;
      else if (do_on) susp_q <= 1'b0;
      if (do_off) xoff_flag_q <= 1'b1;
      else if (do_on) xoff_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  logic in_ready, out_valid, ovr_q;
  logic [10:0] head;
  logic [CW-1:0] cnt;

  rx_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .flush(flush),
    .in_valid(push_v),
    .in_ready(in_ready),
    .in_data(push_d),
    .out_valid(out_valid),
    .out_ready(rd_hold),
    .out_data(head),
    .count(cnt)
  );

  wire [CW-1:0] trig = CW'(trig_level(trig_q));
  wire [CW-1:0] hi_lvl = CW'(upper_level(trig_q));
  wire [CW-1:0] lo_lvl = CW'(lower_level(trig_q));
  wire rx_ready = fifo_en_q ? (cnt >= trig) : out_valid;

  // ----------------------------------------
  // Bit-time divider, timeout and pause-send delay
  // ----------------------------------------
  logic [4:0] bdiv_q;
  logic [6:0] to_q;
  logic [5:0] dly_q;
  logic sent_q, send_q, send_off_q;
  logic [7:0] first_q, second_q;
  wire bit_tick = os_tick & (bdiv_q >= bitclk - 5'd1);
  wire [6:0] to_lim = TIMEOUT_WORDS * {3'b000, wl} + TIMEOUT_EXTRA_BITS;
  wire to_hit = out_valid & (to_q >= to_lim);
  wire [5:0] char_bits = {2'b00, nframe} + {5'b00000, lcr_q[2]} + 6'd2;
  wire [5:0] dly_lim = 6'(XOFF_DELAY_CHARS * char_bits);
  wire auto_tx = (efr_q[3:2] != 2'b00);
  wire tx_dbl = (efr_q[3:2] == 2'b11);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bdiv_q <= 5'd0;
      to_q <= 7'd0;
      dly_q <= 6'd0;
      sent_q <= 1'b0;
      send_q <= 1'b0;
      send_off_q <= 1'b0;
      first_q <= 8'h00;
      second_q <= 8'h00;
    end else begin
      send_q <= 1'b0;
      if (os_tick) bdiv_q <= bit_tick ? 5'd0 : bdiv_q + 5'd1;
      if (char_v | rd_hold | ~out_valid) to_q <= 7'd0;
      else if (bit_tick & ~to_hit) to_q <= to_q + 7'd1;
      if (~auto_tx | sent_q | cnt < trig) dly_q <= 6'd0;
      else if (bit_tick) dly_q <= dly_q + 6'd1;
      if (auto_tx & ~sent_q & cnt >= trig & dly_q >= dly_lim) begin
        sent_q <= 1'b1;
        send_q <= 1'b1;
        send_off_q <= 1'b1;
        first_q <= (efr_q[3:2] == 2'b01) ? off2_q : off1_q;
        second_q <= off2_q;
      end else if (sent_q & cnt <= lo_lvl) begin
        sent_q <= 1'b0;
        send_q <= auto_tx;
        send_off_q <= 1'b0;
        first_q <= (efr_q[3:2] == 2'b01) ? on2_q : on1_q;
        second_q <= on2_q;
      end
    end
  end

  // ----------------------------------------
  // Hardware flow control and status
  // ----------------------------------------
  logic rts_off_q, rts_q, mflag_q, pause_q;
  wire rts_d = efr_q[6] ? (~mcr_q[1] | rts_off_q) : ~mcr_q[1];
  wire rts_rise = rts_d & ~rts_q & ier_q[6] & efr_q[4];
  wire cts_rise = cts_d & ~cts_q & ier_q[7] & efr_q[4];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rts_off_q <= 1'b0;
      rts_q <= 1'b1;
      mflag_q <= 1'b0;
      pause_q <= 1'b0;
      ovr_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (cnt >= hi_lvl) rts_off_q <= 1'b1;
      else if (cnt <= lo_lvl) rts_off_q <= 1'b0;
      rts_q <= rts_d;
      if (rts_rise | cts_rise) mflag_q <= 1'b1;
      else if (rd_isr) mflag_q <= 1'b0;
      pause_q <= (efr_q[7] & cts_q) | susp_q;
      if (push_v & ~in_ready) ovr_q <= 1'b1;
      else if (rd_lsr) ovr_q <= 1'b0;
      if (host_rd) rdata_q <= rd_val;
    end
  end

  wire [2:0] tags = out_valid ? head[10:8] : 3'b000;
  wire [7:0] line_status = {3'b000, tags, ovr_q, out_valid};
  wire [5:0] isr_code = (ier_q[0] & to_hit) ? ISR_TIMEOUT :
                        (ier_q[0] & rx_ready) ? ISR_RX_DATA :
                        (ier_q[5] & xoff_flag_q) ? ISR_XOFF :
                        mflag_q ? ISR_RTSCTS : ISR_NONE;
  wire [7:0] interrupt_status = {fifo_en_q, fifo_en_q, isr_code};
  always_comb begin
    case (host_addr)
      ADDR_HOLD: rd_val = lcr_q[7] ? 8'h00 : head[7:0];
      ADDR_IER: rd_val = lcr_q[7] ? 8'h00 : ier_q;
      ADDR_ISR: rd_val = enh ? efr_q : (divl ? frac_q : interrupt_status);
      ADDR_LCR: rd_val = lcr_q;
      ADDR_MCR: rd_val = enh ? on1_q : mcr_q;
      ADDR_LSR: rd_val = enh ? on2_q : line_status;
      ADDR_PAUSE_CHAR_FIRST: rd_val = enh ? off1_q : 8'h00;
      ADDR_PAUSE_CHAR_SECOND: rd_val = enh ? off2_q : 8'h00;
      default: rd_val = 8'h00;
    endcase
  end

  assign host_rdata = rdata_q;
  assign irq = (isr_code != ISR_NONE);
  assign rts_n = rts_q;
  assign tx_pause = pause_q;
  assign tx_flow_send = send_q;
  assign tx_flow_pause_char = send_off_q;
  assign tx_flow_double = tx_dbl;
  assign tx_flow_first = first_q;
  assign tx_flow_second = second_q;
endmodule // uart_receiver_flow_control
`default_nettype wire
